/* src/rsq_reset_seq.sv */
`timescale 1ns/1ns
module rsq_reset_seq import rsq_pkg::*; (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst_b,
    // Register port
    input  wire rsq_bus_t    bus,
    output logic [7:0]       rd_data,
    // Processor status, same clock
    input  wire rsq_cpu_t    cpu,
    input  wire logic        monitor_mode,
    input  wire logic        break_state,
    // Asynchronous sources
    input  wire logic        power_on_pulse,
    input  wire logic        low_voltage_detect,
    input  wire logic        test_high_voltage_rst,
    input  wire logic        test_high_voltage_irq,
    input  wire logic        se0_in,
    // Shared reset pin
    input  wire logic        rst_pin_in,
    output logic             rst_pin_out,
    output logic             rst_pin_oe,
    // Reset and clock control
    output logic             internal_reset,
    output logic             internal_bus_clocks,
    output logic             clock_generator_output,
    output logic             vector_fetch,
    output logic [15:0]      reset_vector,
    output logic             bus_reset_pulse,
    output logic             bus_reset_irq
);
    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            sync1_reg <= 6'h01;
            sync2_reg <= 6'h01;
        end else begin
            sync1_reg <= {power_on_pulse, low_voltage_detect, test_high_voltage_rst,
                          test_high_voltage_irq, se0_in, rst_pin_in};
            sync2_reg <= sync1_reg;
        end
    end
    logic por_s, lvd_s, tvr_s, tvi_s, se0_s, pin_s;
    assign {por_s, lvd_s, tvr_s, tvi_s, se0_s, pin_s} = sync2_reg;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    rsq_state_t  state_reg;
    logic [11:0] cnt_reg;
    logic [5:0]  ph_reg;
    logic        ext_path_reg;
    logic [7:0]  cause_reg;
    logic [7:0]  ctrl_reg;
    logic [7:0]  busaddr_reg;
    logic [7:0]  wdog_reg;
    logic [3:0]  pin_low_reg;
    logic [8:0]  se0_cnt_reg;
    logic        se0_seen_reg;

    wire wr_svc   = bus.wr && bus.addr == REG_WDOG_SVC;
    wire running  = state_reg == ST_RUN;
    wire cpu_live = running || state_reg == ST_STOP || state_reg == ST_WAKE;
    wire tick     = cnt_reg == CNT_LONG;
    // Watchdog disable is combinational on the synchronised test-voltage levels, gated by monitor_mode or break_state
    wire wdog_dis = (monitor_mode && (tvr_s || tvi_s)) || (break_state && tvr_s);
    wire wdog_ev  = running && tick && !wdog_dis && wdog_reg == WDOG_MAX;
    wire illegal_opcode_flag_ev  = running && (cpu.illegal_op
                    || (cpu.stop_exec && !ctrl_reg[CT_STOP_EN]));
    wire illegal_address_flag_ev  = running && cpu.opcode_fetch && cpu.unmapped;
    wire se0_long = se0_s && se0_cnt_reg >= 9'(SE0_CYC) && busaddr_reg[BA_ENABLE];
    wire usb_ev   = running && se0_long && !se0_seen_reg;
    wire usb_rst  = usb_ev && !ctrl_reg[CT_USB_IRQ];
    wire lvd_ev   = lvd_s && state_reg != ST_POR;
    wire por_ev   = por_s && state_reg != ST_POR;
    wire int_ev   = wdog_ev || illegal_opcode_flag_ev || illegal_address_flag_ev || usb_rst;
    wire pin_ev   = cpu_live && !rst_pin_oe && pin_low_reg == PIN_MIN_CYC
                    && !int_ev && !lvd_ev && !por_ev;
    wire stop_go  = running && cpu.stop_exec && ctrl_reg[CT_STOP_EN] && !int_ev;
    wire [11:0] wake_cnt = ctrl_reg[CT_SHORT_STOP_RECOVERY_OPTION] ? CNT_SHORT : CNT_LONG;

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            state_reg    <= ST_POR;
            ph_reg       <= 6'h00;
            ext_path_reg <= 1'b0;
        end else if (por_ev || lvd_ev) begin
            state_reg    <= ST_POR;
            ext_path_reg <= 1'b0;
        end else begin
            unique case (state_reg)
                ST_RUN, ST_STOP, ST_WAKE: begin
                    ph_reg <= 6'h00;
                    if (int_ev) begin
                        state_reg    <= ST_DRIVE;
                        ext_path_reg <= 1'b0;
                    end else if (pin_ev) begin
                        state_reg    <= ST_EXT;
                        ext_path_reg <= 1'b1;
                    end else if (stop_go) begin
                        state_reg <= ST_STOP;
                    end else if (state_reg == ST_STOP && cpu.wake) begin
                        state_reg <= ST_WAKE;
                    end else if (state_reg == ST_WAKE && cnt_reg >= wake_cnt) begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_POR: begin
                    if (cnt_reg == CNT_LONG) begin
                        state_reg <= ST_DRIVE;
                        ph_reg    <= 6'h00;
                    end
                end
                ST_DRIVE: begin
                    ph_reg <= ph_reg + 6'h01;
                    if (ph_reg == PH_32) begin
                        state_reg <= ST_TAIL;
                        ph_reg    <= 6'h00;
                    end
                end
                ST_EXT: begin
                    ph_reg <= 6'h00;
                    if (pin_s) begin
                        state_reg <= ST_TAIL;
                    end
                end
                ST_TAIL: begin
                    ph_reg <= ph_reg + 6'h01;
                    if (ph_reg == (ext_path_reg ? PH_64 : PH_32)) begin
                        state_reg <= ST_VEC;
                        ph_reg    <= 6'h00;
                    end
                end
                ST_VEC: begin
                    ph_reg <= ph_reg + 6'h01;
                    if (ph_reg == PH_VEC) begin
                        state_reg <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Stabilisation and prescale counter
    // ------------------------------------------------------------
    // Counts in every state except ST_STOP, where it is held at zero, so the watchdog prescale stalls only in stop
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            cnt_reg <= 12'h000;
        // Held at zero through stop so the wake delay counts from the wake-up itself
        end else if (por_ev || lvd_ev || (cpu_live && int_ev)
                     || ((stop_go || state_reg == ST_STOP) && !pin_ev)) begin
            cnt_reg <= 12'h000;
        end else if (wr_svc) begin
            cnt_reg <= cnt_reg & CNT_SVC_MASK;
        end else begin
            cnt_reg <= cnt_reg + 12'h001;
        end
    end

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b || !running || wr_svc) begin
            wdog_reg <= 8'h00;
        end else if (tick && !wdog_dis) begin
            wdog_reg <= wdog_reg + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Pin and bus-reset qualifiers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b || pin_s || rst_pin_oe) begin
            pin_low_reg <= 4'h0;
        end else if (pin_low_reg != PIN_MIN_CYC) begin
            pin_low_reg <= pin_low_reg + 4'h1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !se0_s || !busaddr_reg[BA_ENABLE]) begin
            se0_cnt_reg  <= 9'h000;
            se0_seen_reg <= 1'b0;
        end else begin
            if (se0_cnt_reg < 9'(SE0_CYC)) begin
                se0_cnt_reg <= se0_cnt_reg + 9'h001;
            end
            if (se0_long && running) begin
                se0_seen_reg <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Cause, control and bus address registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b || por_ev) begin
            cause_reg <= 8'h80;
        end else begin
            if (lvd_ev)  cause_reg[CB_LVD]  <= 1'b1;
            if (wdog_ev) cause_reg[CB_WDOG] <= 1'b1;
            if (illegal_opcode_flag_ev) cause_reg[CB_ILLEGAL_OPCODE_FLAG] <= 1'b1;
            if (illegal_address_flag_ev) cause_reg[CB_ILLEGAL_ADDRESS_FLAG] <= 1'b1;
            if (usb_rst) cause_reg[CB_USB]  <= 1'b1;
            if (pin_ev)  cause_reg[CB_PIN]  <= 1'b1;
        end
    end

    // Options are cleared only by a full power-up; other resets leave them as software set them
    always_ff @(posedge clk_sys) begin
        if (!rst_b || por_ev) begin
            ctrl_reg <= CTRL_RST;
        end else if (bus.wr && bus.addr == REG_CTRL) begin
            ctrl_reg <= {5'h00, bus.wdata[2:0]};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || internal_reset) begin
            busaddr_reg <= 8'h00;
        end else if (usb_ev) begin
            busaddr_reg <= {1'b1, 7'h00};
        end else if (bus.wr && bus.addr == REG_BUSADDR) begin
            busaddr_reg <= bus.wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b || !bus.rd) begin
            rd_data <= 8'h00;
        end else begin
            unique case (bus.addr)
                REG_CAUSE:   rd_data <= cause_reg;
                REG_CTRL:    rd_data <= ctrl_reg;
                REG_BUSADDR: rd_data <= busaddr_reg;
                default:     rd_data <= 8'h00;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rst_pin_out            <= 1'b0;
            rst_pin_oe             <= 1'b1;
            internal_reset         <= 1'b1;
            internal_bus_clocks    <= 1'b0;
            clock_generator_output <= 1'b1;
            vector_fetch           <= 1'b0;
            reset_vector           <= VEC_USER;
            bus_reset_pulse        <= 1'b0;
            bus_reset_irq          <= 1'b0;
        end else begin
            rst_pin_out <= 1'b0;
            rst_pin_oe  <= state_reg == ST_POR || state_reg == ST_DRIVE;
            internal_reset <= state_reg inside {ST_POR, ST_DRIVE, ST_EXT, ST_TAIL};
            internal_bus_clocks <= !(state_reg inside {ST_POR, ST_STOP, ST_WAKE});
            clock_generator_output <= 1'b1;
            vector_fetch <= state_reg == ST_VEC;
            reset_vector <= monitor_mode ? VEC_MONITOR : VEC_USER;
            bus_reset_pulse <= usb_ev;
            bus_reset_irq   <= usb_ev && ctrl_reg[CT_USB_IRQ];
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    logic [12:0] por_len_reg;
    always_ff @(posedge clk_sys) begin
        if (!rst_b || state_reg != ST_POR) por_len_reg <= 13'h0000;
        else por_len_reg <= por_len_reg + 13'h0001;
    end

    property p_por_len;
        state_reg == ST_POR |-> por_len_reg <= 13'h1000;
    endproperty
    a_por_len: assert property (p_por_len) else $error("power-on hold too long");

    // Run lengths are counted in helper logic so the checks stay cheap to unroll
    logic [6:0]  drive_len_reg;
    logic [6:0]  tail_len_reg;
    logic [12:0] wake_len_reg;
    always_ff @(posedge clk_sys) begin
        if (!rst_b || state_reg != ST_DRIVE) drive_len_reg <= 7'h00;
        else drive_len_reg <= drive_len_reg + 7'h01;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b || state_reg != ST_TAIL) tail_len_reg <= 7'h00;
        else tail_len_reg <= tail_len_reg + 7'h01;
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_b || state_reg != ST_WAKE) wake_len_reg <= 13'h0000;
        else wake_len_reg <= wake_len_reg + 13'h0001;
    end

    property p_drive_32;
        $past(state_reg) == ST_DRIVE && state_reg != ST_DRIVE && !$past(por_ev) && !$past(lvd_ev)
            |-> state_reg == ST_TAIL && drive_len_reg == 7'h20;
    endproperty
    a_drive_32: assert property (p_drive_32) else $error("pin drive not 32 cycles");

    property p_tail_int;
        $past(state_reg) == ST_TAIL && state_reg != ST_TAIL && !$past(por_ev) && !$past(lvd_ev)
            && !ext_path_reg |-> state_reg == ST_VEC && tail_len_reg == 7'h20;
    endproperty
    a_tail_int: assert property (p_tail_int) else $error("reset tail not 32 cycles");

    property p_tail_ext;
        $past(state_reg) == ST_TAIL && state_reg != ST_TAIL && !$past(por_ev) && !$past(lvd_ev)
            && ext_path_reg |-> state_reg == ST_VEC && tail_len_reg == 7'h40;
    endproperty
    a_tail_ext: assert property (p_tail_ext) else $error("pin reset tail not 64 cycles");

    property p_pin_low;
        state_reg == ST_DRIVE |=> rst_pin_oe && !rst_pin_out;
    endproperty
    a_pin_low: assert property (p_pin_low) else $error("pin not driven low");

    property p_clk_off;
        state_reg == ST_POR |=> !internal_bus_clocks && internal_reset;
    endproperty
    a_clk_off: assert property (p_clk_off) else $error("bus clocks during power-on");

    property p_wdog_flag;
        wdog_ev && !por_ev |=> cause_reg[CB_WDOG] ##1 internal_reset;
    endproperty
    a_wdog_flag: assert property (p_wdog_flag) else $error("watchdog reset missing");

    property p_svc;
        wr_svc && !int_ev && !stop_go && !por_ev && !lvd_ev |=> cnt_reg[11:5] == 7'h00;
    endproperty
    a_svc: assert property (p_svc) else $error("service write left counter");

    property p_ext_keep;
        pin_ev |=> cnt_reg == $past(cnt_reg) + 12'h001;
    endproperty
    a_ext_keep: assert property (p_ext_keep) else $error("pin reset touched counter");

    property p_data_fetch;
        running && cpu.unmapped && !cpu.opcode_fetch && !cpu.illegal_op && !cpu.stop_exec
            && !wdog_ev && !usb_rst |=> !(state_reg == ST_DRIVE);
    endproperty
    a_data_fetch: assert property (p_data_fetch) else $error("data fetch caused reset");

    property p_usb_off;
        !busaddr_reg[BA_ENABLE] |=> !bus_reset_pulse;
    endproperty
    a_usb_off: assert property (p_usb_off) else $error("bus reset while disabled");

    property p_wake_len;
        $past(state_reg) == ST_WAKE && state_reg == ST_RUN
            |-> wake_len_reg == (ctrl_reg[CT_SHORT_STOP_RECOVERY_OPTION] ? 13'h0020 : 13'h1000);
    endproperty
    a_wake_len: assert property (p_wake_len) else $error("stop recovery length wrong");

    property p_stop_clk;
        state_reg inside {ST_STOP, ST_WAKE} |=> !internal_bus_clocks;
    endproperty
    a_stop_clk: assert property (p_stop_clk) else $error("bus clocks during stop recovery");

    property p_int_rst;
        state_reg inside {ST_DRIVE, ST_TAIL} |=> internal_reset && !vector_fetch;
    endproperty
    a_int_rst: assert property (p_int_rst) else $error("internal reset not held");
endmodule

/* src/rsq_pkg.sv */
package rsq_pkg;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int          CLK_PERIOD_NS = 8;
    localparam int          SE0_TIME_NS   = 2500;
    localparam int          SE0_CYC       = (SE0_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [11:0] CNT_LONG      = 12'hFFF;
    localparam logic [11:0] CNT_SHORT     = 12'h01F;
    localparam logic [11:0] CNT_SVC_MASK  = 12'h01F;
    localparam logic [5:0]  PH_32         = 6'h1F;
    localparam logic [5:0]  PH_64         = 6'h3F;
    localparam logic [5:0]  PH_VEC        = 6'h02;
    localparam logic [3:0]  PIN_MIN_CYC   = 4'h4;
    localparam logic [7:0]  WDOG_MAX      = 8'hFF;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] REG_CAUSE     = 16'h0000;
    localparam logic [15:0] REG_CTRL      = 16'h0004;
    localparam logic [15:0] REG_BUSADDR   = 16'h0008;
    localparam logic [15:0] REG_WDOG_SVC  = 16'hFFFF;
    localparam logic [15:0] VEC_USER      = 16'hFFFE;
    localparam logic [15:0] VEC_MONITOR   = 16'hFEFE;
    // Cause register bit positions
    localparam int          CB_POR        = 7;
    localparam int          CB_PIN        = 6;
    localparam int          CB_WDOG       = 5;
    localparam int          CB_ILLEGAL_OPCODE_FLAG       = 4;
    localparam int          CB_ILLEGAL_ADDRESS_FLAG       = 3;
    localparam int          CB_USB        = 2;
    localparam int          CB_LVD        = 1;
    // Control register bit positions
    localparam int          CT_STOP_EN    = 0;
    localparam int          CT_SHORT_STOP_RECOVERY_OPTION      = 1;
    localparam int          CT_USB_IRQ    = 2;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam int          BA_ENABLE     = 7;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } rsq_bus_t;

    typedef struct packed {
        logic opcode_fetch;
        logic illegal_op;
        logic stop_exec;
        logic unmapped;
        logic wake;
    } rsq_cpu_t;

    typedef enum logic [2:0] {
        ST_RUN, ST_POR, ST_DRIVE, ST_TAIL, ST_VEC, ST_EXT, ST_STOP, ST_WAKE
    } rsq_state_t;
endpackage

/* verif/rsq_pin_partner.sv */
`timescale 1ns/1ns
module rsq_pin_partner (
    // Device side of the shared line
    input  wire logic dev_oe,
    input  wire logic dev_out,
    // Outside peripheral pulling the line
    input  wire logic pull_low,
    output logic      pin_level
);
    // ----------------------------------------
    // Wired-AND line with pull-up
    // ----------------------------------------
    // Either party may sink the line, nobody drives it high, so no contention
    assign pin_level = ~((dev_oe & ~dev_out) | pull_low);
endmodule

/* verif/rsq_reset_seq_tb_top.sv */
`timescale 1ns/1ns
module rsq_reset_seq_tb_top import rsq_pkg::*; ;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk_sys, rst_b, monitor_mode, low_voltage_detect, se0_in, pull_low, pin_level;
    rsq_bus_t    bus;
    rsq_cpu_t    cpu;
    logic [7:0]  rd_data, exp_cause;
    logic [15:0] reset_vector, vec, oe_n, rec_n, off_n, np, ni, nr;
    logic        rst_pin_out, rst_pin_oe, internal_reset, internal_bus_clocks;
    logic        clock_generator_output, vector_fetch, bus_reset_pulse, bus_reset_irq;
    int          fails = 0;
    int          comparisons = 0;

    rsq_reset_seq u_rsq_reset_seq (
        .clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .rd_data(rd_data), .cpu(cpu),
        .monitor_mode(monitor_mode), .break_state(1'b0), .power_on_pulse(1'b0),
        .low_voltage_detect(low_voltage_detect), .test_high_voltage_rst(1'b0),
        .test_high_voltage_irq(1'b0), .se0_in(se0_in), .rst_pin_in(pin_level),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .internal_reset(internal_reset),
        .internal_bus_clocks(internal_bus_clocks), .clock_generator_output(clock_generator_output),
        .vector_fetch(vector_fetch), .reset_vector(reset_vector),
        .bus_reset_pulse(bus_reset_pulse), .bus_reset_irq(bus_reset_irq)
    );

    rsq_pin_partner u_rsq_pin_partner (
        .dev_oe(rst_pin_oe), .dev_out(rst_pin_out), .pull_low(pull_low), .pin_level(pin_level)
    );

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic test_done;
        $display("Counts: %0d comparisons, %0d mismatches", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
        comparisons++;
        if (((got >= lo) && (got <= hi)) !== 1'b1) begin
            fails++;
            $display("MISMATCH at %0t ns: got %0h expected %0h", $time, got, lo);
        end
    endtask

    task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        @(negedge clk_sys);
        chk({8'h00, rd_data}, {8'h00, e}, {8'h00, e});
    endtask

    task automatic cpu_pulse(input logic [4:0] v);
        @(posedge clk_sys);
        cpu <= rsq_cpu_t'(v);
        @(posedge clk_sys);
        cpu <= '0;
    endtask

    // Counts pin drive, recovery span and clock-off time until the sequence ends
    task automatic run_reset(input int lim);
        oe_n = '0;
        rec_n = '0;
        off_n = '0;
        vec = '0;
        for (int i = 0; i < lim; i++) begin
            @(negedge clk_sys);
            if (rst_pin_oe === 1'b1) oe_n++;
            if (internal_bus_clocks === 1'b0) off_n++;
            if (vector_fetch === 1'b1) vec = reset_vector;
            if (internal_reset === 1'b1 || vector_fetch === 1'b1) rec_n++;
            else if (rec_n != 0) break;
        end
    endtask

    task automatic se0_episode;
        np = '0;
        ni = '0;
        nr = '0;
        se0_in <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            @(negedge clk_sys);
            if (bus_reset_pulse === 1'b1) np++;
            if (bus_reset_irq === 1'b1) ni++;
            if (internal_reset === 1'b1 || vector_fetch === 1'b1) nr++;
        end
        @(posedge clk_sys);
        se0_in <= 1'b0;
    endtask

    // ----------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        #(8 * 40000);
        fails++;
        test_done();
    end

    initial begin
        rst_b = 1'b0;
        bus = '0;
        cpu = '0;
        monitor_mode = 1'b0;
        low_voltage_detect = 1'b0;
        se0_in = 1'b0;
        pull_low = 1'b0;
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        exp_cause = 8'h80;
        run_reset(5000);
        chk(oe_n, 16'h1020, 16'h1022);
        chk(rec_n, 16'h1043, 16'h1045);
        chk(off_n, 16'h1000, 16'h1045);
        chk(vec, VEC_USER, VEC_USER);
        chk({15'h0000, clock_generator_output}, 16'h0001, 16'h0001);
        reg_rd(REG_CAUSE, exp_cause);
        $display("Test power-on sequence done");
        reg_wr(REG_CTRL, 8'hFF);
        reg_rd(REG_CTRL, 8'h07);
        reg_wr(REG_CAUSE, 8'h00);
        reg_rd(REG_CAUSE, exp_cause);
        reg_rd(16'h0002, 8'h00);
        reg_wr(REG_WDOG_SVC, 8'h5A);
        reg_wr(REG_CTRL, 8'h00);
        cpu_pulse(5'h02);
        run_reset(50);
        chk(rec_n, 16'h0000, 16'h0000);
        $display("Test registers and quiet accesses done");
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_sys);
            monitor_mode <= (k == 1);
            cpu_pulse(k == 0 ? 5'h04 : (k == 1 ? 5'h08 : 5'h12));
            run_reset(200);
            exp_cause = exp_cause | ((k == 2) ? 8'h08 : 8'h10);
            chk(oe_n, 16'h0020, 16'h0020);
            chk(rec_n, 16'h0043, 16'h0043);
            chk(vec, k == 1 ? VEC_MONITOR : VEC_USER, k == 1 ? VEC_MONITOR : VEC_USER);
            reg_rd(REG_CAUSE, exp_cause);
        end
        monitor_mode <= 1'b0;
        $display("Test internal resets done");
        for (int k = 0; k < 2; k++) begin
            @(posedge clk_sys);
            pull_low <= 1'b1;
            repeat (k ? 12 : 2) @(posedge clk_sys);
            pull_low <= 1'b0;
            run_reset(300);
            chk(rec_n, k ? 16'h0043 : 16'h0000, k ? 16'h0060 : 16'h0000);
            chk(oe_n, 16'h0000, 16'h0000);
        end
        exp_cause = exp_cause | 8'h40;
        reg_rd(REG_CAUSE, exp_cause);
        $display("Test pin reset done");
        for (int k = 0; k < 3; k++) begin
            reg_wr(REG_CTRL, k == 1 ? 8'h04 : 8'h00);
            reg_wr(REG_BUSADDR, k == 0 ? 8'h05 : 8'h85);
            se0_episode();
            chk(np, k == 0 ? 16'h0000 : 16'h0001, k == 0 ? 16'h0000 : 16'h0001);
            chk(ni, k == 1 ? 16'h0001 : 16'h0000, k == 1 ? 16'h0001 : 16'h0000);
            chk(nr, k == 2 ? 16'h0043 : 16'h0000, k == 2 ? 16'h0043 : 16'h0000);
            if (k == 1) reg_rd(REG_BUSADDR, 8'h80);
        end
        exp_cause = exp_cause | 8'h04;
        reg_rd(REG_CAUSE, exp_cause);
        reg_wr(REG_BUSADDR, 8'h85);
        reg_rd(REG_BUSADDR, 8'h85);
        $display("Test serial bus reset done");
        for (int k = 0; k < 2; k++) begin
            reg_wr(REG_CTRL, k == 0 ? 8'h03 : 8'h01);
            cpu_pulse(5'h04);
            repeat (40) @(negedge clk_sys);
            chk({15'h0000, internal_bus_clocks}, 16'h0000, 16'h0000);
            cpu_pulse(5'h01);
            off_n = '0;
            while (internal_bus_clocks !== 1'b1 && off_n < 16'h2000) begin
                @(negedge clk_sys);
                off_n++;
            end
            chk(off_n, k == 0 ? 16'h0010 : 16'h0FF0, k == 0 ? 16'h0024 : 16'h1004);
        end
        $display("Test stop recovery done");
        @(posedge clk_sys);
        low_voltage_detect <= 1'b1;
        fork
            begin
                repeat (4) @(posedge clk_sys);
                low_voltage_detect <= 1'b0;
            end
        join_none
        run_reset(5000);
        chk(oe_n, 16'h1020, 16'h1021);
        chk(rec_n, 16'h1043, 16'h1044);
        exp_cause = exp_cause | 8'h02;
        reg_rd(REG_CAUSE, exp_cause);
        $display("Test low voltage reset done");
        test_done();
    end
endmodule
